// ### hw/eir_map.svh
`ifndef EIR_MAP_SVH
`define EIR_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// byte offsets of the register slice
`define EIR_OFS_STATUS 8'h0C
`define EIR_OFS_PENDING 8'h10
`define EIR_OFS_ENABLE 8'h14
`define EIR_OFS_TX_TAG 8'h18
`define EIR_OFS_RX_TAG 8'h1C
`define EIR_OFS_UA_LOW 8'h20
`define EIR_OFS_UA_HIGH 8'h24
`define EIR_OFS_TPID_01 8'h28
`define EIR_OFS_TPID_23 8'h2C

////////////////////////////////////////////////////////////////////////////////
// interrupt condition bit positions
`define EIR_BIT_ACCESS 0
`define EIR_BIT_NEG 1
`define EIR_BIT_RX_DONE 2
`define EIR_BIT_DROP 3
`define EIR_BIT_OVR 4
`define EIR_BIT_TX_DONE 5
`define EIR_BIT_LOCK 6
`define EIR_BIT_MAC 7
`define EIR_BIT_PHY 8

////////////////////////////////////////////////////////////////////////////////
// reset values and field positions
`define EIR_STATUS_RST 9'h040
`define EIR_IRQ_RST 9'h000
`define EIR_WORD_RST 32'h0000_0000
`define EIR_HALF_RST 16'h0000
`define EIR_GROUP_BIT 0
`define EIR_TPID_HI_LSB 16

////////////////////////////////////////////////////////////////////////////////
// phy wait time and clock rate
`define EIR_PHY_WAIT_MS 5
`define EIR_CLK_KHZ 40000

`endif

// ### hw/eir_pkg.sv
package eir_pkg;
    // width of the interrupt condition vector
    localparam int EIR_IRQ_W = 9;
    // counter width for the phy wait, holds 200000
    localparam int EIR_PHY_CNT_W = 18;

    // one vlan tag word as software sees it
    typedef struct packed {
        logic [15:0] tpid;
        logic [2:0] prio;
        logic cfi;
        logic [11:0] vid;
    } eir_vlan_tag_t;

    typedef logic [EIR_IRQ_W-1:0] eir_irq_vec_t;

    // phy release tracking states
    typedef enum logic [1:0] {
        EIR_PHY_HOLD = 2'b00,
        EIR_PHY_WAIT = 2'b01,
        EIR_PHY_READY = 2'b10
    } eir_phy_st_t;
endpackage

// ### hw/eir_stat_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eir_stat_if;
    import eir_pkg::*;
    eir_irq_vec_t set_evt; // condition sources, level
    eir_irq_vec_t clr; // write-one-to-clear pulse
    eir_irq_vec_t status; // latched status
    eir_irq_vec_t status_nxt; // next latched status
    modport core (input set_evt, input clr, output status, output status_nxt);
    modport regs (output set_evt, output clr, input status, input status_nxt);
endinterface
`default_nettype wire

// ### hw/eir_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "eir_map.svh"
module eir_status #(
    parameter int unsigned P_PHY_WAIT_CYC = `EIR_PHY_WAIT_MS * `EIR_CLK_KHZ
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_phy_reset_out_n,
    output logic o_phy_ready,
    eir_stat_if.core st
);
    import eir_pkg::*;

    localparam logic [EIR_PHY_CNT_W-1:0] WAIT_LAST = EIR_PHY_CNT_W'(P_PHY_WAIT_CYC - 1);

    eir_irq_vec_t status_ff; // sticky conditions
    eir_irq_vec_t nxt_status;
    eir_irq_vec_t src; // sources including phy ready
    eir_phy_st_t phy_st_ff; // phy release state
    eir_phy_st_t nxt_phy_st;
    logic [EIR_PHY_CNT_W-1:0] cnt_ff; // cycles since phy reset release
    logic [EIR_PHY_CNT_W-1:0] nxt_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // phy ready only after the full wait with reset released
    always_comb begin
        nxt_phy_st = phy_st_ff;
        nxt_cnt = cnt_ff;
        case (phy_st_ff)
            EIR_PHY_HOLD: begin
                nxt_cnt = '0;
                if (i_phy_reset_out_n) begin
                    nxt_phy_st = EIR_PHY_WAIT;
                end
            end
            EIR_PHY_WAIT: begin
                nxt_cnt = cnt_ff + EIR_PHY_CNT_W'(1'b1);
                if (cnt_ff == WAIT_LAST) begin
                    nxt_phy_st = EIR_PHY_READY;
                end
            end
            EIR_PHY_READY: begin
                nxt_cnt = cnt_ff;
            end
            default: begin
                nxt_phy_st = EIR_PHY_HOLD;
            end
        endcase
        // any new reset pulse restarts the wait from zero
        if (!i_phy_reset_out_n) begin
            nxt_phy_st = EIR_PHY_HOLD;
            nxt_cnt = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latch: a source in the clear cycle wins over the clear
    always_comb begin
        src = st.set_evt;
        src[`EIR_BIT_PHY] = (phy_st_ff == EIR_PHY_READY);
        nxt_status = (status_ff & ~st.clr) | src;
    end

    assign st.status = status_ff;
    assign st.status_nxt = nxt_status;

    ////////////////////////////////////////////////////////////////////////////
    // register stage
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            status_ff <= `EIR_STATUS_RST;
            phy_st_ff <= EIR_PHY_HOLD;
            cnt_ff <= '0;
            o_phy_ready <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            phy_st_ff <= nxt_phy_st;
            cnt_ff <= nxt_cnt;
            o_phy_ready <= (nxt_phy_st == EIR_PHY_READY);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence clr_alone_s;
        st.clr[`EIR_BIT_ACCESS] && !st.set_evt[`EIR_BIT_ACCESS];
    endsequence
    sequence quiet_s;
        !st.set_evt[`EIR_BIT_ACCESS];
    endsequence
    w1c_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        clr_alone_s ##1 quiet_s |-> !status_ff[`EIR_BIT_ACCESS])
        else $error("status bit not cleared by write one");
    sticky_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        status_ff[`EIR_BIT_TX_DONE] && !st.clr[`EIR_BIT_TX_DONE] |=> status_ff[`EIR_BIT_TX_DONE])
        else $error("status bit lost without clear");
    phy_wait_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $rose(o_phy_ready) |-> $past(cnt_ff) == WAIT_LAST && $past(i_phy_reset_out_n))
        else $error("phy ready rose before wait ended");
    phy_drop_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_phy_reset_out_n |=> !o_phy_ready)
        else $error("phy ready kept during phy reset");
endmodule
`default_nettype wire

// ### hw/eir_regs.sv
// Operation
// - pending equals status AND enable, continuously
// - interrupt high whenever any pending bit set
// - pending is read only, writes ignored
// - bits above eight read zero
// - phy ready waits 5 ms after release
// - mac ready gates mac register access
// - clock lock source stuck at one
// - tx done, overflow, reject raise conditions
// - rx done, negotiation, access raise conditions
// - enable bits writable, reset to zero
// - tx tag value feeds transmit insertion
// - tag word fields writable, reset zero
// - rx tag value feeds receive insertion
// - drop unicast frames not matching address
// - address split low word, high half
// - four tpid slots, match marks vlan
// - tpid words only with vlan options
// - second tpid word holds slots two, three
// - status latches, cleared by writing one
`timescale 1ns/1ps
`default_nettype none
`include "eir_map.svh"
module eir_regs #(
    parameter bit BUILD_TX_TAG_INSERT = 1'b1,
    parameter bit BUILD_RX_TAG_INSERT = 1'b1,
    parameter bit BUILD_TX_TAG_STRIP = 1'b0,
    parameter bit BUILD_RX_TAG_STRIP = 1'b0,
    parameter bit BUILD_TX_TAG_TRANSLATE = 1'b0,
    parameter bit BUILD_RX_TAG_TRANSLATE = 1'b0,
    parameter bit BUILD_EXTENDED_GROUP_FILTER = 1'b1,
    parameter int unsigned P_PHY_WAIT_CYC = `EIR_PHY_WAIT_MS * `EIR_CLK_KHZ
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic I_REG_WR_EN,
    input wire logic I_REG_RD_EN,
    input wire logic [31:0] I_REG_WDATA,
    output logic [31:0] O_REG_RDATA,
    output logic O_REG_RD_VALID,
    input wire logic I_PHY_RESET_OUT_N,
    input wire logic I_MAC_READY_EVENT,
    input wire logic I_TX_DONE_EVENT,
    input wire logic I_RX_BUFFER_OVERFLOW_EVENT,
    input wire logic I_RX_FRAME_DROPPED_EVENT,
    input wire logic I_RX_DONE_EVENT,
    input wire logic I_LINK_NEGOTIATION_DONE_EVENT,
    input wire logic I_MAC_REG_ACCESS_DONE_EVENT,
    input wire logic I_EXT_FILTER_ENABLE,
    input wire logic I_RX_DEST_VALID,
    input wire logic [47:0] I_RX_DEST_ADDR,
    input wire logic I_TYPE_VALID,
    input wire logic [15:0] I_TYPE_FIELD,
    output logic O_IRQ,
    output logic O_MAC_READY,
    output logic O_PHY_READY,
    output eir_pkg::eir_vlan_tag_t O_TX_TAG,
    output eir_pkg::eir_vlan_tag_t O_RX_TAG,
    output logic [47:0] O_UNICAST_ADDR,
    output logic [63:0] O_VLAN_TYPE_IDS,
    output logic O_UNICAST_DROP,
    output logic O_VLAN_MATCH
);
    import eir_pkg::*;

    // tpid words exist only when some vlan option is built
    localparam bit HAS_TPID = BUILD_TX_TAG_INSERT | BUILD_RX_TAG_INSERT |
        BUILD_TX_TAG_STRIP | BUILD_RX_TAG_STRIP |
        BUILD_TX_TAG_TRANSLATE | BUILD_RX_TAG_TRANSLATE;

    eir_stat_if st (); // status latch link

    ////////////////////////////////////////////////////////////////////////////
    // register state
    eir_irq_vec_t enable_ff; // interrupt enables
    eir_irq_vec_t nxt_enable;
    eir_vlan_tag_t tx_tag_ff; // transmit insertion tag
    eir_vlan_tag_t nxt_tx_tag;
    eir_vlan_tag_t rx_tag_ff; // receive insertion tag
    eir_vlan_tag_t nxt_rx_tag;
    logic [31:0] ua_low_ff; // unicast_match_value bits 31..0
    logic [31:0] nxt_ua_low;
    logic [15:0] ua_high_ff; // unicast_match_value bits 47..32
    logic [15:0] nxt_ua_high;
    logic [31:0] tpid01_ff; // slots zero and one
    logic [31:0] nxt_tpid01;
    logic [31:0] tpid23_ff; // slots two and three
    logic [31:0] nxt_tpid23;
    logic [31:0] rdata_ff; // read answer
    logic [31:0] nxt_rdata;
    logic rvalid_ff; // read answer strobe
    logic irq_ff; // interrupt line
    logic nxt_irq;
    logic mac_ready_ff; // mac may be accessed
    logic drop_ff; // unicast filter verdict
    logic nxt_drop;
    logic match_ff; // tpid match verdict
    logic nxt_match;
    logic [3:0] slot_hit; // per-slot tpid compare
    logic [15:0] slot_val [4]; // tpid slot values
    eir_irq_vec_t pending; // status masked by enables
    eir_irq_vec_t clr_vec; // write-one-to-clear pulse
    eir_irq_vec_t src_vec; // condition sources

    ////////////////////////////////////////////////////////////////////////////
    // write strobe decode, shared by every register
    function automatic logic wr_hit(input logic [7:0] ofs);
        return I_REG_WR_EN && (I_REG_ADDR == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // condition sources into the status latch
    always_comb begin
        src_vec = '0;
        src_vec[`EIR_BIT_ACCESS] = I_MAC_REG_ACCESS_DONE_EVENT;
        src_vec[`EIR_BIT_NEG] = I_LINK_NEGOTIATION_DONE_EVENT;
        src_vec[`EIR_BIT_RX_DONE] = I_RX_DONE_EVENT;
        src_vec[`EIR_BIT_DROP] = I_RX_FRAME_DROPPED_EVENT;
        src_vec[`EIR_BIT_OVR] = I_RX_BUFFER_OVERFLOW_EVENT;
        src_vec[`EIR_BIT_TX_DONE] = I_TX_DONE_EVENT;
        // obsolete lock source kept high so the bit never stays cleared
        src_vec[`EIR_BIT_LOCK] = 1'b1;
        src_vec[`EIR_BIT_MAC] = I_MAC_READY_EVENT;
        // the phy bit is filled in by the status module's own timer
        clr_vec = '0;
        if (wr_hit(`EIR_OFS_STATUS)) begin
            clr_vec = I_REG_WDATA[EIR_IRQ_W-1:0];
        end
    end

    assign st.set_evt = src_vec;
    assign st.clr = clr_vec;

    eir_status #(
        .P_PHY_WAIT_CYC(P_PHY_WAIT_CYC)
    ) u_status (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_phy_reset_out_n(I_PHY_RESET_OUT_N),
        .o_phy_ready(O_PHY_READY),
        .st(st.core)
    );

    // pending is a view only, never stored
    assign pending = st.status & enable_ff;

    ////////////////////////////////////////////////////////////////////////////
    // register writes; the pending offset has no write path at all
    always_comb begin
        nxt_enable = enable_ff;
        nxt_tx_tag = tx_tag_ff;
        nxt_rx_tag = rx_tag_ff;
        nxt_ua_low = ua_low_ff;
        nxt_ua_high = ua_high_ff;
        nxt_tpid01 = tpid01_ff;
        nxt_tpid23 = tpid23_ff;
        if (wr_hit(`EIR_OFS_ENABLE)) begin
            // upper bits dropped so they keep reading zero
            nxt_enable = I_REG_WDATA[EIR_IRQ_W-1:0];
        end
        if (wr_hit(`EIR_OFS_TX_TAG) && BUILD_TX_TAG_INSERT) begin
            nxt_tx_tag = eir_vlan_tag_t'(I_REG_WDATA);
        end
        if (wr_hit(`EIR_OFS_RX_TAG) && BUILD_RX_TAG_INSERT) begin
            nxt_rx_tag = eir_vlan_tag_t'(I_REG_WDATA);
        end
        if (wr_hit(`EIR_OFS_UA_LOW) && BUILD_EXTENDED_GROUP_FILTER) begin
            nxt_ua_low = I_REG_WDATA;
        end
        if (wr_hit(`EIR_OFS_UA_HIGH) && BUILD_EXTENDED_GROUP_FILTER) begin
            // only the low half is kept, the rest is reserved
            nxt_ua_high = I_REG_WDATA[15:0];
        end
        if (wr_hit(`EIR_OFS_TPID_01) && HAS_TPID) begin
            nxt_tpid01 = I_REG_WDATA;
        end
        if (wr_hit(`EIR_OFS_TPID_23) && HAS_TPID) begin
            nxt_tpid23 = I_REG_WDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets answer zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (I_REG_RD_EN) begin
            case (I_REG_ADDR)
                `EIR_OFS_STATUS: nxt_rdata = 32'(st.status);
                `EIR_OFS_PENDING: nxt_rdata = 32'(pending);
                `EIR_OFS_ENABLE: nxt_rdata = 32'(enable_ff);
                `EIR_OFS_TX_TAG: nxt_rdata = tx_tag_ff;
                `EIR_OFS_RX_TAG: nxt_rdata = rx_tag_ff;
                `EIR_OFS_UA_LOW: nxt_rdata = ua_low_ff;
                `EIR_OFS_UA_HIGH: nxt_rdata = 32'(ua_high_ff);
                `EIR_OFS_TPID_01: nxt_rdata = tpid01_ff;
                `EIR_OFS_TPID_23: nxt_rdata = tpid23_ff;
                default: nxt_rdata = `EIR_WORD_RST;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // tpid slot compare; any slot hit marks the frame as vlan
    assign slot_val[0] = tpid01_ff[`EIR_TPID_HI_LSB-1:0];
    assign slot_val[1] = tpid01_ff[31:`EIR_TPID_HI_LSB];
    assign slot_val[2] = tpid23_ff[`EIR_TPID_HI_LSB-1:0];
    assign slot_val[3] = tpid23_ff[31:`EIR_TPID_HI_LSB];
    for (genvar g = 0; g < 4; g++) begin : g_slot
        assign slot_hit[g] = (slot_val[g] == I_TYPE_FIELD);
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt and unicast filter next values
    always_comb begin
        // built from next values so the line tracks pending without lag
        nxt_irq = |(st.status_nxt & nxt_enable);
        // group bit clear in the first byte means a unicast frame
        nxt_drop = BUILD_EXTENDED_GROUP_FILTER && I_EXT_FILTER_ENABLE &&
            I_RX_DEST_VALID && !I_RX_DEST_ADDR[`EIR_GROUP_BIT] &&
            (I_RX_DEST_ADDR != {ua_high_ff, ua_low_ff});
        nxt_match = HAS_TPID && I_TYPE_VALID && (|slot_hit);
    end

    ////////////////////////////////////////////////////////////////////////////
    // register stage, synchronous reset
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
            enable_ff <= `EIR_IRQ_RST;
            tx_tag_ff <= `EIR_WORD_RST;
            rx_tag_ff <= `EIR_WORD_RST;
            ua_low_ff <= `EIR_WORD_RST;
            ua_high_ff <= `EIR_HALF_RST;
            tpid01_ff <= `EIR_WORD_RST;
            tpid23_ff <= `EIR_WORD_RST;
            rdata_ff <= `EIR_WORD_RST;
            rvalid_ff <= 1'b0;
            irq_ff <= 1'b0;
            mac_ready_ff <= 1'b0;
            drop_ff <= 1'b0;
            match_ff <= 1'b0;
        end else begin
            enable_ff <= nxt_enable;
            tx_tag_ff <= nxt_tx_tag;
            rx_tag_ff <= nxt_rx_tag;
            ua_low_ff <= nxt_ua_low;
            ua_high_ff <= nxt_ua_high;
            tpid01_ff <= nxt_tpid01;
            tpid23_ff <= nxt_tpid23;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= I_REG_RD_EN;
            irq_ff <= nxt_irq;
            // mac side ready follows the mac ready event, one cycle later
            mac_ready_ff <= I_MAC_READY_EVENT;
            drop_ff <= nxt_drop;
            match_ff <= nxt_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign O_REG_RDATA = rdata_ff;
    assign O_REG_RD_VALID = rvalid_ff;
    assign O_IRQ = irq_ff;
    assign O_MAC_READY = mac_ready_ff;
    assign O_TX_TAG = tx_tag_ff;
    assign O_RX_TAG = rx_tag_ff;
    assign O_UNICAST_ADDR = {ua_high_ff, ua_low_ff};
    assign O_VLAN_TYPE_IDS = {tpid23_ff, tpid01_ff};
    assign O_UNICAST_DROP = drop_ff;
    assign O_VLAN_MATCH = match_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);

    sequence rd_pend_s;
        I_REG_RD_EN && I_REG_ADDR == `EIR_OFS_PENDING;
    endsequence
    sequence rd_high_s;
        I_REG_RD_EN && I_REG_ADDR == `EIR_OFS_UA_HIGH;
    endsequence

    pend_view_a: assert property (rd_pend_s |=>
        O_REG_RD_VALID && O_REG_RDATA == 32'($past(st.status) & $past(enable_ff)))
        else $error("pending read differs from status and enable");
    irq_level_a: assert property (O_IRQ == |(st.status & enable_ff))
        else $error("interrupt line disagrees with pending");
    pend_ro_a: assert property (I_REG_WR_EN && I_REG_ADDR == `EIR_OFS_PENDING |=>
        enable_ff == $past(enable_ff) && (st.status & $past(st.status)) == $past(st.status))
        else $error("pending write changed enables");
    resv_zero_a: assert property (I_REG_RD_EN && (I_REG_ADDR == `EIR_OFS_PENDING ||
        I_REG_ADDR == `EIR_OFS_ENABLE) |=> O_REG_RDATA[31:EIR_IRQ_W] == '0)
        else $error("reserved interrupt bits not zero");
    mac_ready_a: assert property (I_MAC_READY_EVENT |=> O_MAC_READY
        && st.status[`EIR_BIT_MAC])
        else $error("mac ready not reported");
    lock_one_a: assert property ($past(I_RST_N) |-> st.status[`EIR_BIT_LOCK])
        else $error("lock status bit not one");
    tx_event_a: assert property (I_TX_DONE_EVENT ##1 1'b1 |->
        st.status[`EIR_BIT_TX_DONE] ##1
        (st.status[`EIR_BIT_TX_DONE] || $past(clr_vec[`EIR_BIT_TX_DONE])))
        else $error("tx done condition not latched");
    rx_event_a: assert property (I_RX_DONE_EVENT |=> st.status[`EIR_BIT_RX_DONE])
        else $error("rx done condition not latched");
    enable_wr_a: assert property (wr_hit(`EIR_OFS_ENABLE) |=>
        enable_ff == $past(I_REG_WDATA[EIR_IRQ_W-1:0]))
        else $error("enable write not stored");
    tx_tag_a: assert property (wr_hit(`EIR_OFS_TX_TAG) && BUILD_TX_TAG_INSERT |=>
        O_TX_TAG == $past(I_REG_WDATA))
        else $error("tx tag write not stored");
    ua_high_a: assert property (rd_high_s |=> O_REG_RDATA[31:16] == '0)
        else $error("unicast high reserved bits not zero");
    drop_a: assert property (BUILD_EXTENDED_GROUP_FILTER && I_EXT_FILTER_ENABLE &&
        I_RX_DEST_VALID && !I_RX_DEST_ADDR[`EIR_GROUP_BIT] &&
        I_RX_DEST_ADDR != O_UNICAST_ADDR |=> O_UNICAST_DROP)
        else $error("unicast mismatch not dropped");
    match_keep_a: assert property (I_RX_DEST_VALID &&
        I_RX_DEST_ADDR == O_UNICAST_ADDR |=> !O_UNICAST_DROP)
        else $error("matching unicast frame dropped");
    tpid23_a: assert property (wr_hit(`EIR_OFS_TPID_23) && HAS_TPID |=>
        O_VLAN_TYPE_IDS[63:32] == $past(I_REG_WDATA))
        else $error("second tpid word not stored");
    tpid_match_a: assert property (I_TYPE_VALID && HAS_TPID &&
        I_TYPE_FIELD == tpid01_ff[15:0] |=> O_VLAN_MATCH)
        else $error("tpid slot zero match missed");
endmodule
`default_nettype wire

// ### sim/eir_host.sv
`timescale 1ns/1ps
`default_nettype none
// host model on the strobe register bus, one access per task call
module eir_host (
    input wire logic clk,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    output logic [7:0] addr,
    output logic wr,
    output logic rd,
    output logic [31:0] wdata
);
    initial begin
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 32'h0000_0000;
    end
    // single-cycle write strobe, data scrambled after release
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        wdata = ~v;
        addr = ~a;
    endtask
    // answer comes one edge after the strobe; a missing answer gives unknown
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        addr = ~a;
        v = (rvalid === 1'b1) ? rdata : 32'hXXXX_XXXX;
    endtask
endmodule
`default_nettype wire

// ### sim/test_eir_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "eir_map.svh"
module test_eir_regs;
    import eir_pkg::*;
    localparam int P = 8; // short phy wait for simulation
    logic clk, rst_n, phy_n, mac, ext, dv, tv, wr, rd, rv, irq, mrdy, prdy, drop, vm;
    logic [5:0] ev;
    logic [7:0] addr;
    logic [15:0] typ;
    logic [31:0] wdata, rdata, r, a0, a1;
    logic [47:0] dest, ua, u;
    logic [63:0] ids;
    eir_vlan_tag_t tx_vlan_tag_value, rx_vlan_tag_value;
    integer seed = 12011;
    int err_count = 0;
    int samples_checked = 0;
    int n;
    eir_host host_u (.clk(clk), .rdata(rdata), .rvalid(rv), .addr(addr), .wr(wr), .rd(rd),
        .wdata(wdata));
    eir_regs #(.P_PHY_WAIT_CYC(P)) dut_u (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr),
        .I_REG_WR_EN(wr), .I_REG_RD_EN(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
        .O_REG_RD_VALID(rv), .I_PHY_RESET_OUT_N(phy_n), .I_MAC_READY_EVENT(mac),
        .I_TX_DONE_EVENT(ev[5]), .I_RX_BUFFER_OVERFLOW_EVENT(ev[4]),
        .I_RX_FRAME_DROPPED_EVENT(ev[3]), .I_RX_DONE_EVENT(ev[2]),
        .I_LINK_NEGOTIATION_DONE_EVENT(ev[1]), .I_MAC_REG_ACCESS_DONE_EVENT(ev[0]),
        .I_EXT_FILTER_ENABLE(ext), .I_RX_DEST_VALID(dv), .I_RX_DEST_ADDR(dest),
        .I_TYPE_VALID(tv), .I_TYPE_FIELD(typ), .O_IRQ(irq), .O_MAC_READY(mrdy),
        .O_PHY_READY(prdy), .O_TX_TAG(tx_vlan_tag_value), .O_RX_TAG(rx_vlan_tag_value), .O_UNICAST_ADDR(ua),
        .O_VLAN_TYPE_IDS(ids), .O_UNICAST_DROP(drop), .O_VLAN_MATCH(vm));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    // expectation and compare helpers
    function automatic logic exp_drop(input logic e, input logic [47:0] s, input logic [47:0] t);
        return e & ~t[0] & (t != s); // only unicast frames are filtered
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        host_u.rd_reg(a, r);
        chk(nm, {32'h0, e}, {32'h0, r});
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // watchdog, the tests need well under a thousand cycles
    initial begin
        #100000;
        err_count++;
        summarize();
    end
    initial begin
        {rst_n, phy_n, mac, ext, dv, tv, ev, dest, typ} = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        rdchk(`EIR_OFS_STATUS, 32'h40, "status");
        for (int a = 8'h10; a <= 8'h2C; a += 4) rdchk(a[7:0], 32'h0, "reset");
        a0 = $random(seed);
        host_u.wr_reg(`EIR_OFS_ENABLE, a0);
        rdchk(`EIR_OFS_ENABLE, a0 & 32'h1FF, "enable");
        host_u.wr_reg(`EIR_OFS_STATUS, 32'hFFFF_FFFF);
        rdchk(`EIR_OFS_STATUS, 32'h40, "lock");
        // each event: latch, mask, unmask, write-one clear
        for (int b = 0; b < 6; b++) begin
            host_u.wr_reg(`EIR_OFS_ENABLE, 32'h1 << b);
            @(negedge clk);
            ev[b] = 1'b1;
            @(negedge clk);
            ev = '0;
            @(negedge clk);
            chk("irq", 1, irq);
            host_u.wr_reg(`EIR_OFS_PENDING, 32'h1FF);
            rdchk(`EIR_OFS_PENDING, 32'h1 << b, "pending");
            host_u.wr_reg(`EIR_OFS_ENABLE, 32'h0);
            rdchk(`EIR_OFS_PENDING, 32'h0, "masked");
            chk("irq off", 0, irq);
            host_u.wr_reg(`EIR_OFS_ENABLE, 32'h1BF);
            rdchk(`EIR_OFS_PENDING, 32'h1 << b, "held");
            host_u.wr_reg(`EIR_OFS_STATUS, 32'h1 << b);
            rdchk(`EIR_OFS_PENDING, 32'h0, "cleared");
        end
        host_u.wr_reg(`EIR_OFS_ENABLE, 32'h40);
        chk("lock irq", 1, irq);
        host_u.wr_reg(`EIR_OFS_ENABLE, 32'h0);
        // tag words, random contents
        for (int i = 0; i < 3; i++) begin
            a0 = $random(seed);
            a1 = $random(seed);
            host_u.wr_reg(`EIR_OFS_TX_TAG, a0);
            host_u.wr_reg(`EIR_OFS_RX_TAG, a1);
            rdchk(`EIR_OFS_TX_TAG, a0, "tx tag");
            rdchk(`EIR_OFS_RX_TAG, a1, "rx tag");
            chk("tx out", a0, tx_vlan_tag_value);
            chk("rx out", a1, rx_vlan_tag_value);
        end
        // unicast address and filtering
        a0 = $random(seed) & 32'hFFFF_FFFE;
        a1 = $random(seed);
        u = {a1[15:0], a0};
        host_u.wr_reg(`EIR_OFS_UA_LOW, a0);
        host_u.wr_reg(`EIR_OFS_UA_HIGH, a1);
        rdchk(`EIR_OFS_UA_HIGH, a1 & 32'hFFFF, "ua high");
        chk("ua", u, ua);
        for (int k = 0; k < 5; k++) begin
            @(negedge clk);
            // filtering is only turned on once the mac filter is promiscuous
            ext = (k != 4);
            dest = (k == 0) ? u : (k == 1) ? u ^ 48'h100 : (k == 2) ? u | 48'h1 : u ^ 48'h2;
            dv = 1'b1;
            @(negedge clk);
            dv = 1'b0;
            chk("drop", exp_drop(ext, u, dest), drop);
        end
        // common type ids in the four slots
        host_u.wr_reg(`EIR_OFS_TPID_01, 32'h9100_8100);
        host_u.wr_reg(`EIR_OFS_TPID_23, 32'h88A8_9200);
        chk("ids", 64'h88A8_9200_9100_8100, ids);
        for (int k = 0; k < 6; k++) begin
            @(negedge clk);
            typ = (k < 4) ? 16'(64'h88A8_9200_9100_8100 >> (16 * k)) : 16'h0800 + k[15:0];
            tv = 1'b1;
            @(negedge clk);
            tv = 1'b0;
            chk("vlan", k < 4, vm);
        end
        // mac ready, then phy release timing
        @(negedge clk);
        mac = 1'b1;
        @(negedge clk);
        chk("mac ready", 1, mrdy);
        phy_n = 1'b1;
        n = 0;
        while (prdy !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk("phy wait", P + 1, n);
        rdchk(`EIR_OFS_STATUS, 32'h1C0, "ready bits");
        summarize();
    end
endmodule
`default_nettype wire
